// [logic/pxs_pkg.sv]
// constants and types shared by the proximity sequencer
package pxs_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_MHZ      = 20;
    localparam int unsigned STEP_NS      = 2_730_000;
    localparam int unsigned STEP_CYC     = (STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LED_ON_NS    = 7_300;
    localparam int unsigned LED_ON_CYC   = (LED_ON_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned LED_PER_NS   = 16_000;
    localparam int unsigned LED_PER_CYC  = (LED_PER_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  STRETCH_M1   = 4'hb;
    localparam logic [9:0]  STEP_MAX_CNT = 10'h3ff;

    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] ADR_ENABLE = 5'h00;
    localparam logic [4:0] ADR_CONVERSION_STEPS  = 5'h02;
    localparam logic [4:0] ADR_WAIT_STEPS  = 5'h03;
    localparam logic [4:0] ADR_LO_L   = 5'h08;
    localparam logic [4:0] ADR_LO_H   = 5'h09;
    localparam logic [4:0] ADR_HI_L   = 5'h0a;
    localparam logic [4:0] ADR_HI_H   = 5'h0b;
    localparam logic [4:0] ADR_CONSECUTIVE_MISS_CONFIG   = 5'h0c;
    localparam logic [4:0] ADR_CFG    = 5'h0d;
    localparam logic [4:0] ADR_PULSE  = 5'h0e;
    localparam logic [4:0] ADR_CTL    = 5'h0f;
    localparam logic [4:0] ADR_REV    = 5'h11;
    localparam logic [4:0] ADR_ID     = 5'h12;
    localparam logic [4:0] ADR_STATUS = 5'h13;
    localparam logic [4:0] ADR_RES_L  = 5'h18;
    localparam logic [4:0] ADR_RES_H  = 5'h19;
    localparam logic [4:0] ADR_OFFSET = 5'h1e;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int unsigned EN_PON  = 0;
    localparam int unsigned EN_PEN  = 2;
    localparam int unsigned EN_WEN  = 3;
    localparam int unsigned EN_MASK = 5;
    localparam int unsigned EN_SAI  = 6;
    localparam logic [7:0]  EN_WMSK = 8'h6d;
    localparam logic [7:0]  CONSECUTIVE_MISS_CONFIG_WMSK = 8'hf0;
    localparam int unsigned CFG_WAIT_STRETCH = 1;
    localparam int unsigned ST_VALID  = 1;
    localparam int unsigned ST_INT    = 5;
    localparam int unsigned ST_SAT    = 6;
    localparam logic [7:0]  CONVERSION_STEPS_RST = 8'hff;
    localparam logic [7:0]  WAIT_STEPS_RST = 8'hff;

    typedef enum logic [1:0] {
        REQ_START = 2'h0,
        REQ_WRITE = 2'h1,
        REQ_READ  = 2'h2,
        REQ_CLEAR = 2'h3
    } pxs_req_t;

    typedef enum logic [6:0] {
        S_SLEEP = 7'h01,
        S_IDLE  = 7'h02,
        S_INIT  = 7'h04,
        S_ACCUM = 7'h08,
        S_PWAIT = 7'h10,
        S_ADC   = 7'h20,
        S_WAIT  = 7'h40
    } pxs_state_t;

endpackage

// [logic/pxs_sequencer.sv]
// proximity sequencer: power states, led pulses, result, interrupt
// Overview of operation
// - reset lands the device in sleep
// - bus start wakes to idle; no power sleeps
// - idle waits detection enable; cycle repeats
// - interrupt with sleep-on-event returns to sleep
// - init, accumulate, wait, adc; fixed steps
// - programmed led pulses, fixed on and period
// - led current level picks sink strength
// - on minus off accumulates over pulses
// - saturation flag sticky until interrupt clear
// - result is 16 bits in two bytes
// - adc steps follow conversion steps setting
// - signed crosstalk offset shifts the result
// - valid flag set after cycle, cleared by disable
// - status always evaluated; mask gates pin only
// - below low or above high is out-of-range
// - low compared first; inverted limits ignore high
// - interrupt after filter count of misses
// - interrupt holds until clear command
// - interrupt asserted at end of adc step
// - optional wait state, stretch multiplies twelve
// - 0xff gives one step, up to 256
// - wait steps equal 256 minus value
// - interrupt clear is a self-clearing command
// - filter zero fires every cycle
`timescale 1ns/100ps
`default_nettype none

module pxs_sequencer #(
    parameter int unsigned STEP_CYCLES = pxs_pkg::STEP_CYC,
    parameter logic [7:0]  REV_CODE    = 8'h01,
    parameter logic [7:0]  ID_CODE     = 8'h5a
) (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       link_clk,
    input  wire logic       link_rst,
    input  wire logic       lk_start,
    input  wire logic       lk_wr,
    input  wire logic       lk_rd,
    input  wire logic       lk_clr,
    input  wire logic [4:0] lk_addr,
    input  wire logic [7:0] lk_wdata,
    output logic            lk_busy,
    output logic            lk_done,
    output logic [7:0]      lk_rdata,
    input  wire logic [9:0] afe_level,
    input  wire logic       afe_sat,
    output logic            led_sink_output,
    output logic [1:0]      led_current_level,
    output logic [1:0]      photodiode_select,
    output logic            osc_run,
    output logic            int_o,
    output logic            int_oe
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        pxs_pkg::pxs_state_t st;
        logic [19:0]         tmr;
        logic [8:0]          steps;
        logic [3:0]          mul;
        logic [8:0]          ph;
        logic [7:0]          pls;
        logic [9:0]          on_smp;
        logic signed [19:0]  acc;
        logic [17:0]         sum;
        logic [7:0]          en;
        logic [7:0]          conversion_steps;
        logic [7:0]          wait_steps;
        logic [7:0]          consecutive_miss_config;
        logic [7:0]          cfg;
        logic [7:0]          led_pulse_count;
        logic [7:0]          ctl;
        logic [7:0]          off;
        logic [15:0]         lo;
        logic [15:0]         hi;
        logic [15:0]         res;
        logic                sat;
        logic                intr;
        logic                valid;
        logic                led;
        logic [3:0]          miss;
        logic [2:0]          rq_s;
        logic                rq_seen;
        logic                ack_t;
        logic [7:0]          rdata;
    } pxs_core_t;

    typedef struct packed {
        logic              req_t;
        logic [2:0]        ak_s;
        logic              ak_seen;
        logic              busy;
        logic              done;
        pxs_pkg::pxs_req_t kind;
        logic [4:0]        addr;
        logic [7:0]        wdata;
        logic [7:0]        rdata;
    } pxs_link_t;

    pxs_core_t c_r;
    pxs_core_t c_nxt;
    pxs_link_t l_r;
    pxs_link_t l_nxt;

    logic               evt;
    logic               clr;
    logic               oor;
    logic               fire;
    logic [17:0]        sum_n;
    logic signed [19:0] sres;
    logic [15:0]        res_n;
    logic [3:0]         miss_n;

    localparam logic [19:0] STEP_M1 = 20'(STEP_CYCLES - 1);

    // two's complement step count
    function automatic logic [8:0] nsteps(input logic [7:0] v);
        nsteps = 9'h100 - {1'b0, v};
    endfunction

    // per-step converter ceiling; negative differences read as zero
    function automatic logic [9:0] clamp(input logic signed [19:0] a);
        if (a < 0) begin
            clamp = 10'h000;
        end else if (a > $signed({10'h000, pxs_pkg::STEP_MAX_CNT})) begin
            clamp = pxs_pkg::STEP_MAX_CNT;
        end else begin
            clamp = a[9:0];
        end
    endfunction

    // ****************************************
    // core domain
    // ****************************************
    always_comb begin
        c_nxt  = c_r;
        clr    = 1'b0;
        oor    = 1'b0;
        fire   = 1'b0;
        sum_n  = c_r.sum;
        sres   = 20'sh0_0000;
        res_n  = c_r.res;
        miss_n = c_r.miss;

        // requests from the link arrive as a toggle
        c_nxt.rq_s = {c_r.rq_s[1:0], l_r.req_t};
        evt = (c_r.rq_s[1] == c_r.rq_s[2]) && (c_r.rq_s[2] != c_r.rq_seen);
        if (evt) begin
            c_nxt.rq_seen = c_r.rq_s[2];
            c_nxt.ack_t   = ~c_r.ack_t;
            unique case (l_r.kind)
                pxs_pkg::REQ_WRITE: begin
                    unique case (l_r.addr)
                        pxs_pkg::ADR_ENABLE: c_nxt.en = l_r.wdata & pxs_pkg::EN_WMSK;
                        pxs_pkg::ADR_CONVERSION_STEPS:  c_nxt.conversion_steps = l_r.wdata;
                        pxs_pkg::ADR_WAIT_STEPS:  c_nxt.wait_steps = l_r.wdata;
                        pxs_pkg::ADR_LO_L:   c_nxt.lo[7:0] = l_r.wdata;
                        pxs_pkg::ADR_LO_H:   c_nxt.lo[15:8] = l_r.wdata;
                        pxs_pkg::ADR_HI_L:   c_nxt.hi[7:0] = l_r.wdata;
                        pxs_pkg::ADR_HI_H:   c_nxt.hi[15:8] = l_r.wdata;
                        pxs_pkg::ADR_CONSECUTIVE_MISS_CONFIG:   c_nxt.consecutive_miss_config = l_r.wdata & pxs_pkg::CONSECUTIVE_MISS_CONFIG_WMSK;
                        pxs_pkg::ADR_CFG:    c_nxt.cfg = l_r.wdata;
                        pxs_pkg::ADR_PULSE:  c_nxt.led_pulse_count = l_r.wdata;
                        pxs_pkg::ADR_CTL:    c_nxt.ctl = l_r.wdata;
                        pxs_pkg::ADR_OFFSET: c_nxt.off = l_r.wdata;
                        default: ;
                    endcase
                end
                pxs_pkg::REQ_READ: begin
                    unique case (l_r.addr)
                        pxs_pkg::ADR_ENABLE: c_nxt.rdata = c_r.en;
                        pxs_pkg::ADR_CONVERSION_STEPS:  c_nxt.rdata = c_r.conversion_steps;
                        pxs_pkg::ADR_WAIT_STEPS:  c_nxt.rdata = c_r.wait_steps;
                        pxs_pkg::ADR_LO_L:   c_nxt.rdata = c_r.lo[7:0];
                        pxs_pkg::ADR_LO_H:   c_nxt.rdata = c_r.lo[15:8];
                        pxs_pkg::ADR_HI_L:   c_nxt.rdata = c_r.hi[7:0];
                        pxs_pkg::ADR_HI_H:   c_nxt.rdata = c_r.hi[15:8];
                        pxs_pkg::ADR_CONSECUTIVE_MISS_CONFIG:   c_nxt.rdata = c_r.consecutive_miss_config;
                        pxs_pkg::ADR_CFG:    c_nxt.rdata = c_r.cfg;
                        pxs_pkg::ADR_PULSE:  c_nxt.rdata = c_r.led_pulse_count;
                        pxs_pkg::ADR_CTL:    c_nxt.rdata = c_r.ctl;
                        pxs_pkg::ADR_REV:    c_nxt.rdata = REV_CODE;
                        pxs_pkg::ADR_ID:     c_nxt.rdata = ID_CODE;
                        pxs_pkg::ADR_STATUS: begin
                            c_nxt.rdata = 8'h00;
                            c_nxt.rdata[pxs_pkg::ST_VALID] = c_r.valid;
                            c_nxt.rdata[pxs_pkg::ST_INT]   = c_r.intr;
                            c_nxt.rdata[pxs_pkg::ST_SAT]   = c_r.sat;
                        end
                        pxs_pkg::ADR_RES_L:  c_nxt.rdata = c_r.res[7:0];
                        pxs_pkg::ADR_RES_H:  c_nxt.rdata = c_r.res[15:8];
                        pxs_pkg::ADR_OFFSET: c_nxt.rdata = c_r.off;
                        default:             c_nxt.rdata = 8'h00;
                    endcase
                end
                pxs_pkg::REQ_CLEAR: clr = 1'b1;
                pxs_pkg::REQ_START: ;
            endcase
        end

        // clears first so that a same-cycle set wins
        if (clr) begin
            c_nxt.intr = 1'b0;
            c_nxt.sat  = 1'b0;
            c_nxt.miss = 4'h0;
            miss_n     = 4'h0;
        end

        if (c_r.tmr != 20'h0_0000) begin
            c_nxt.tmr = c_r.tmr - 20'h0_0001;
        end

        unique case (c_r.st)
            pxs_pkg::S_SLEEP: begin
                if (evt) begin
                    c_nxt.st = pxs_pkg::S_IDLE;
                end
            end
            pxs_pkg::S_IDLE: begin
                if (!c_r.en[pxs_pkg::EN_PON]) begin
                    c_nxt.st = pxs_pkg::S_SLEEP;
                end else if (c_r.en[pxs_pkg::EN_PEN]) begin
                    c_nxt.st  = pxs_pkg::S_INIT;
                    c_nxt.tmr = STEP_M1;
                end
            end
            pxs_pkg::S_INIT: begin
                if (c_r.tmr == 20'h0_0000) begin
                    c_nxt.acc = 20'sh0_0000;
                    c_nxt.ph  = 9'h000;
                    c_nxt.pls = 8'h00;
                    if (c_r.led_pulse_count == 8'h00) begin
                        c_nxt.st  = pxs_pkg::S_PWAIT;
                        c_nxt.tmr = STEP_M1;
                    end else begin
                        c_nxt.st = pxs_pkg::S_ACCUM;
                    end
                end
            end
            pxs_pkg::S_ACCUM: begin
                c_nxt.ph = c_r.ph + 9'h001;
                if (c_r.ph == 9'(pxs_pkg::LED_ON_CYC - 1)) begin
                    c_nxt.on_smp = afe_level;
                end
                if (c_r.led && afe_sat) begin
                    c_nxt.sat = 1'b1;
                end
                if (c_r.ph == 9'(pxs_pkg::LED_PER_CYC - 1)) begin
                    c_nxt.ph  = 9'h000;
                    c_nxt.pls = c_r.pls + 8'h01;
                    c_nxt.acc = c_r.acc + $signed({10'h000, c_r.on_smp})
                              - $signed({10'h000, afe_level});
                    if (c_r.pls + 8'h01 == c_r.led_pulse_count) begin
                        c_nxt.st  = pxs_pkg::S_PWAIT;
                        c_nxt.tmr = STEP_M1;
                    end
                end
            end
            pxs_pkg::S_PWAIT: begin
                if (c_r.tmr == 20'h0_0000) begin
                    c_nxt.st    = pxs_pkg::S_ADC;
                    c_nxt.tmr   = STEP_M1;
                    c_nxt.steps = nsteps(c_r.conversion_steps);
                    c_nxt.sum   = 18'h0_0000;
                end
            end
            pxs_pkg::S_ADC: begin
                if (c_r.tmr == 20'h0_0000) begin
                    sum_n       = c_r.sum + {8'h00, clamp(c_r.acc)};
                    c_nxt.sum   = sum_n;
                    c_nxt.steps = c_r.steps - 9'h001;
                    c_nxt.tmr   = STEP_M1;
                    if (c_r.steps == 9'h001) begin
                        sres = $signed({2'b00, sum_n})
                             + $signed({{12{c_r.off[7]}}, c_r.off});
                        if (sres < 0) begin
                            res_n = 16'h0000;
                        end else if (sres > 20'sh0_ffff) begin
                            res_n = 16'hffff;
                        end else begin
                            res_n = sres[15:0];
                        end
                        c_nxt.res   = res_n;
                        c_nxt.valid = 1'b1;
                        // low limit first; high only counts when limits are ordered
                        oor = (res_n < c_r.lo)
                            || ((c_r.lo <= c_r.hi) && (res_n > c_r.hi));
                        if (c_r.consecutive_miss_config[7:4] == 4'h0) begin
                            fire = 1'b1;
                        end else if (oor) begin
                            miss_n = (miss_n == 4'hf) ? 4'hf : miss_n + 4'h1;
                            fire   = (miss_n >= c_r.consecutive_miss_config[7:4]);
                        end else begin
                            miss_n = 4'h0;
                        end
                        c_nxt.miss = miss_n;
                        if (fire) begin
                            c_nxt.intr = 1'b1;
                        end
                        if (fire && c_r.en[pxs_pkg::EN_SAI]) begin
                            c_nxt.st = pxs_pkg::S_SLEEP;
                        end else if (c_r.en[pxs_pkg::EN_WEN]) begin
                            c_nxt.st    = pxs_pkg::S_WAIT;
                            c_nxt.steps = nsteps(c_r.wait_steps);
                            c_nxt.mul   = c_r.cfg[pxs_pkg::CFG_WAIT_STRETCH]
                                        ? pxs_pkg::STRETCH_M1 : 4'h0;
                        end else begin
                            c_nxt.st = pxs_pkg::S_IDLE;
                        end
                    end
                end
            end
            pxs_pkg::S_WAIT: begin
                if (c_r.tmr == 20'h0_0000) begin
                    c_nxt.tmr = STEP_M1;
                    if (c_r.mul != 4'h0) begin
                        c_nxt.mul = c_r.mul - 4'h1;
                    end else if (c_r.steps != 9'h001) begin
                        c_nxt.steps = c_r.steps - 9'h001;
                        c_nxt.mul   = c_r.cfg[pxs_pkg::CFG_WAIT_STRETCH]
                                    ? pxs_pkg::STRETCH_M1 : 4'h0;
                    end else begin
                        c_nxt.st = pxs_pkg::S_IDLE;
                    end
                end
            end
            default: c_nxt.st = pxs_pkg::S_SLEEP;
        endcase

        // losing power or detection aborts a running cycle
        if (!(c_r.st inside {pxs_pkg::S_SLEEP, pxs_pkg::S_IDLE})
            && !(c_r.en[pxs_pkg::EN_PON] && c_r.en[pxs_pkg::EN_PEN])) begin
            c_nxt.st = pxs_pkg::S_IDLE;
        end

        // a cycle ending as detection drops must not leave the flag set
        if (!c_r.en[pxs_pkg::EN_PEN] || !c_nxt.en[pxs_pkg::EN_PEN]) begin
            c_nxt.valid = 1'b0;
        end

        c_nxt.led = (c_nxt.st == pxs_pkg::S_ACCUM)
                  && (c_nxt.ph < 9'(pxs_pkg::LED_ON_CYC));
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            c_r       <= '0;
            c_r.st    <= pxs_pkg::S_SLEEP;
            c_r.conversion_steps <= pxs_pkg::CONVERSION_STEPS_RST;
            c_r.wait_steps <= pxs_pkg::WAIT_STEPS_RST;
        end else begin
            c_r <= c_nxt;
        end
    end

    // ****************************************
    // link domain
    // ****************************************
    always_comb begin
        l_nxt      = l_r;
        l_nxt.done = 1'b0;
        l_nxt.ak_s = {l_r.ak_s[1:0], c_r.ack_t};
        // core rdata is stable once its ack toggle is seen here
        if ((l_r.ak_s[1] == l_r.ak_s[2]) && (l_r.ak_s[2] != l_r.ak_seen)) begin
            l_nxt.ak_seen = l_r.ak_s[2];
            l_nxt.busy    = 1'b0;
            l_nxt.done    = 1'b1;
            l_nxt.rdata   = c_r.rdata;
        end
        if (!l_r.busy && (lk_start || lk_wr || lk_rd || lk_clr)) begin
            l_nxt.busy  = 1'b1;
            l_nxt.req_t = ~l_r.req_t;
            l_nxt.addr  = lk_addr;
            l_nxt.wdata = lk_wdata;
            if (lk_clr) begin
                l_nxt.kind = pxs_pkg::REQ_CLEAR;
            end else if (lk_wr) begin
                l_nxt.kind = pxs_pkg::REQ_WRITE;
            end else if (lk_rd) begin
                l_nxt.kind = pxs_pkg::REQ_READ;
            end else begin
                l_nxt.kind = pxs_pkg::REQ_START;
            end
        end
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            l_r <= '0;
        end else begin
            l_r <= l_nxt;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign lk_busy           = l_r.busy;
    assign lk_done           = l_r.done;
    assign lk_rdata          = l_r.rdata;
    assign led_sink_output   = c_r.led;
    assign led_current_level = c_r.ctl[7:6];
    assign photodiode_select = c_r.ctl[5:4];
    assign osc_run           = c_r.en[pxs_pkg::EN_PON];
    assign int_o             = 1'b0;
    assign int_oe            = c_r.intr && c_r.en[pxs_pkg::EN_MASK];

    // ****************************************
    // checks
    // ****************************************
    chk_reset_sleep: assert property (
        @(posedge core_clk) disable iff (rst)
        $fell(rst) |-> c_r.st == pxs_pkg::S_SLEEP)
        else $error("not asleep after reset");

    chk_idle_nopower: assert property (
        @(posedge core_clk) disable iff (rst)
        (c_r.st == pxs_pkg::S_IDLE) && !c_r.en[pxs_pkg::EN_PON] && !evt
        |=> c_r.st == pxs_pkg::S_SLEEP)
        else $error("idle without power did not sleep");

    chk_led_width: assert property (
        @(posedge core_clk)
        disable iff (rst || !(c_r.en[pxs_pkg::EN_PON] && c_r.en[pxs_pkg::EN_PEN]))
        $rose(led_sink_output) |-> led_sink_output [*8] ##1 (c_r.st == pxs_pkg::S_ACCUM))
        else $error("led pulse too short");

    chk_sat_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        c_r.sat && !clr |=> c_r.sat)
        else $error("saturation flag dropped");

    chk_valid_drop: assert property (
        @(posedge core_clk) disable iff (rst)
        !c_r.en[pxs_pkg::EN_PEN] |=> !c_r.valid)
        else $error("valid flag kept without detection");

    chk_pin_gate: assert property (
        @(posedge core_clk) disable iff (rst)
        int_oe |-> c_r.intr && c_r.en[pxs_pkg::EN_MASK])
        else $error("pin driven without interrupt");

    chk_inverted_lim: assert property (
        @(posedge core_clk) disable iff (rst)
        (c_r.lo > c_r.hi) && (res_n >= c_r.lo) |-> !oor)
        else $error("high limit used with inverted limits");

    chk_int_hold: assert property (
        @(posedge core_clk) disable iff (rst)
        c_r.intr && !clr |=> c_r.intr)
        else $error("interrupt dropped without clear");

    chk_sai_sleep: assert property (
        @(posedge core_clk) disable iff (rst)
        fire && c_r.en[pxs_pkg::EN_SAI] && c_r.en[pxs_pkg::EN_PON]
        && c_r.en[pxs_pkg::EN_PEN] |=> (c_r.st == pxs_pkg::S_SLEEP) && c_r.intr)
        else $error("no sleep after interrupt");

    chk_req_busy: assert property (
        @(posedge link_clk) disable iff (link_rst)
        lk_clr && !l_r.busy |=> l_r.busy && (l_r.kind == pxs_pkg::REQ_CLEAR))
        else $error("clear request not taken");

endmodule
`default_nettype wire

// [verif/pxs_host.sv]
// host model: one link request at a time, waits for the answer
`timescale 1ns/100ps
`default_nettype none
module pxs_host (
    input  wire logic       link_clk,
    input  wire logic       lk_busy,
    input  wire logic       lk_done,
    input  wire logic [7:0] lk_rdata,
    output logic            lk_start,
    output logic            lk_wr,
    output logic            lk_rd,
    output logic            lk_clr,
    output logic [4:0]      lk_addr,
    output logic [7:0]      lk_wdata
);
    initial {lk_start, lk_wr, lk_rd, lk_clr, lk_addr, lk_wdata} = 17'h0_0000;
    // kind is {start, write, read, clear}; addr and data held until done
    task automatic req(input logic [3:0] kind, input logic [4:0] adr,
                       input logic [7:0] dat, output logic [7:0] rd);
        @(posedge link_clk);
        while (lk_busy !== 1'b0) @(posedge link_clk);
        {lk_start, lk_wr, lk_rd, lk_clr} <= kind;
        lk_addr <= adr;
        lk_wdata <= dat;
        @(posedge link_clk);
        {lk_start, lk_wr, lk_rd, lk_clr} <= 4'h0;
        // a lost answer is caught by the bench cycle ceiling
        while (lk_done !== 1'b1) @(posedge link_clk);
        rd = lk_rdata;
    endtask
endmodule
`default_nettype wire

// [verif/proximity_sequencer_interrupt_test.sv]
// self-checking bench for the proximity sequencer
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module proximity_sequencer_interrupt_test;
    logic       core_clk, link_clk, rst, lk_busy, lk_done, afe_sat, led_sink_output;
    logic       lk_start, lk_wr, lk_rd, lk_clr, osc_run, int_o, int_oe;
    logic [4:0] lk_addr;
    logic [7:0] lk_wdata, lk_rdata, rd, ofs;
    logic [9:0] afe_level;
    logic [1:0] led_current_level, photodiode_select;
    logic [15:0] e;
    int         err_count, num_checks, cyc, seed, per, last_rise, lr;
    logic       led_q;
    localparam int STEP = 20;
    pxs_sequencer #(.STEP_CYCLES(STEP)) pxs_sequencer_i (.core_clk(core_clk), .rst(rst),
        .link_clk(link_clk), .link_rst(rst), .lk_start(lk_start), .lk_wr(lk_wr),
        .lk_rd(lk_rd), .lk_clr(lk_clr), .lk_addr(lk_addr), .lk_wdata(lk_wdata),
        .lk_busy(lk_busy), .lk_done(lk_done), .lk_rdata(lk_rdata), .afe_level(afe_level),
        .afe_sat(afe_sat), .led_sink_output(led_sink_output), .osc_run(osc_run),
        .led_current_level(led_current_level), .photodiode_select(photodiode_select),
        .int_o(int_o), .int_oe(int_oe));
    pxs_host pxs_host_i (.link_clk(link_clk), .lk_busy(lk_busy), .lk_done(lk_done),
        .lk_rdata(lk_rdata), .lk_start(lk_start), .lk_wr(lk_wr), .lk_rd(lk_rd),
        .lk_clr(lk_clr), .lk_addr(lk_addr), .lk_wdata(lk_wdata));
    initial begin core_clk = 0; forever #25 core_clk = ~core_clk; end
    initial begin link_clk = 0; #3.7; forever #6 link_clk = ~link_clk; end
    // negative offset clamps the result at zero; afe held flat gives on minus off = 0
    function automatic logic [15:0] exp_res(input logic [7:0] o);
        return o[7] ? 16'h0000 : {8'h00, o};
    endfunction
    // one pulse, one adc step: idle, init, accumulate, prox wait, adc, then wait steps
    function automatic int exp_per(input logic [7:0] wt, input logic wl);
        return 1 + 3 * STEP + pxs_pkg::LED_PER_CYC + (256 - wt) * (wl ? 12 : 1) * STEP;
    endfunction
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        pxs_host_i.req(4'h4, a, d, rd);
    endtask
    task automatic rchk(input string nm, input logic [4:0] a, input logic [7:0] ex);
        pxs_host_i.req(4'h2, a, 8'h00, rd);
        `CHK(nm, ex, rd)
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        led_q <= led_sink_output;
        if (led_sink_output && !led_q) begin
            per <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (cyc == 20000) begin
            err_count++;
            print_verdict;
        end
    end
    initial begin
        seed = 19; err_count = 0; num_checks = 0; cyc = 0;
        rst = 1; afe_level = 10'h000; afe_sat = 0;
        repeat (20) @(posedge core_clk);
        rst <= 0;
        repeat (4) @(posedge core_clk);
        `CHK("osc", 1'b0, osc_run)
        rchk("conversion_steps", 5'h02, 8'hff);
        rchk("wait_steps", 5'h03, 8'hff);
        rchk("unmapped", 5'h1f, 8'h00);
        wr(5'h00, 8'hda);
        rchk("enable", 5'h00, 8'h48);
        `CHK("osc", 1'b0, osc_run)
        wr(5'h0f, 8'h90);
        `CHK("drive", 2'h2, led_current_level)
        `CHK("diode", 2'h1, photodiode_select)
        wr(5'h0e, 8'h01);
        for (int k = 0; k < 4; k++) begin
            ofs = (k == 1) ? 8'hf0 : (8'($random(seed)) & 8'h7f);
            e = exp_res(ofs);
            @(posedge core_clk);
            afe_level <= 10'($random(seed));
            afe_sat <= (k == 2);
            wr(5'h1e, ofs);
            wr(5'h00, 8'h25);
            for (int n = 0; n < 3000 && int_oe !== 1'b1; n++) @(posedge core_clk);
            `CHK("pin", 1'b1, int_oe)
            rchk("res_lo", 5'h18, e[7:0]);
            rchk("res_hi", 5'h19, e[15:8]);
            rchk("status", 5'h13, {1'b0, k == 2, 4'h8, 2'h2});
            wr(5'h00, 8'h21);
            pxs_host_i.req(4'h1, 5'h00, 8'h00, rd);
            rchk("cleared", 5'h13, 8'h00);
            `CHK("pin_off", 1'b0, int_oe)
        end
        wr(5'h0c, 8'h20);
        wr(5'h08, 8'h08);
        wr(5'h0a, 8'h05);
        wr(5'h1e, 8'h10);
        wr(5'h00, 8'h05);
        repeat (1500) @(posedge core_clk);
        rchk("inverted", 5'h13, 8'h02);
        wr(5'h08, 8'h00);
        repeat (1500) @(posedge core_clk);
        rchk("above", 5'h13, 8'h22);
        `CHK("masked", 1'b0, int_oe)
        wr(5'h03, 8'hfe);
        wr(5'h0d, 8'h02);
        wr(5'h00, 8'h0d);
        repeat (2700) @(posedge core_clk);
        `CHK("period", exp_per(8'hfe, 1'b1), per)
        wr(5'h00, 8'h45);
        repeat (1000) @(posedge core_clk);
        lr = last_rise;
        repeat (1000) @(posedge core_clk);
        `CHK("asleep", lr, last_rise)
        pxs_host_i.req(4'h8, 5'h00, 8'h00, rd);
        repeat (100) @(posedge core_clk);
        `CHK("woke", 1'b1, last_rise != lr)
        `CHK("int_o", 1'b0, int_o)
        print_verdict;
    end
endmodule
`default_nettype wire
